// ===== inc/rocs_defs.svh
// constants for the reset and oscillator configuration sequencer
`ifndef ROCS_DEFS_SVH
`define ROCS_DEFS_SVH
`define ROCS_CLK_MHZ        100
`define ROCS_POR_US         10
`define ROCS_POR_CYC        (`ROCS_POR_US * `ROCS_CLK_MHZ)
`define ROCS_SETTLE_US      100
`define ROCS_SETTLE_CYC     (`ROCS_SETTLE_US * `ROCS_CLK_MHZ)
`define ROCS_PWRT4_MS       4
`define ROCS_PWRT16_MS      16
`define ROCS_PWRT64_MS      64
`define ROCS_MS_CYC         (1000 * `ROCS_CLK_MHZ)
`define ROCS_MASTER_CLEAR_PIN_FILT_CYC  16
`define ROCS_Q_DIV          4
// register byte offsets
`define ROCS_OFF_TRIM       12'h000
`define ROCS_OFF_CFG        12'h004
`define ROCS_OFF_STAT       12'h008
`define ROCS_OFF_OSC        12'h00C
// reset status bit positions
`define ROCS_ST_BOR         1
`define ROCS_ST_POR         0
`define ROCS_ST_SLEEP       3
`define ROCS_ST_WDTO        4
`define ROCS_ST_SWR         6
`define ROCS_ST_EXTR        7
`define ROCS_ST_IOP         14
`define ROCS_ST_TRAP        15
// oscillator groups and fields
`define ROCS_GRP_PLL        3'b111
`define ROCS_GRP_EXT        3'b011
`define ROCS_GRP_LOW_POWER_RC_OSC       3'b010
`define ROCS_GRP_FRC        3'b001
`define ROCS_GRP_SOSC       3'b000
`define ROCS_CFG_RESET      24'h00_C1_00
`endif

// ===== inc/rocs_pkg.sv
// types for the reset and oscillator configuration sequencer
`default_nettype none
package rocs_pkg;
   typedef enum logic [2:0]
   {
      ROCS_HOLD    = 3'b000,
      ROCS_PORWAIT = 3'b001,
      ROCS_PWRWAIT = 3'b011,
      ROCS_Q1WAIT  = 3'b010,
      ROCS_RUN     = 3'b110
   } rocs_state_t;
   typedef struct packed
   {
      logic [1:0] switch_monitor_cfg;
      logic [2:0] poweron_osc_group;
      logic [4:0] primary_osc_select;
      logic [1:0] powerup_timer;
   } rocs_cfg_t;
   typedef struct packed
   {
      logic sw_reset;
      logic wdt_timeout;
      logic wdt_wake;
      logic trap_lockup;
      logic illegal_op;
   } rocs_src_t;
endpackage
`default_nettype wire

// ===== logic/rocs_sequencer.sv
// reset sequencer with oscillator configuration and apb registers
//
// Implementation choices: the address map and the APB interface to the registers.
`include "rocs_defs.svh"
`default_nettype none
module rocs_sequencer
   import rocs_pkg::*;
#(
   parameter int POR_CYC    = `ROCS_POR_CYC,
   parameter int SETTLE_CYC = `ROCS_SETTLE_CYC,
   parameter int MS_CYC     = `ROCS_MS_CYC,
   parameter int FILT_CYC   = `ROCS_MASTER_CLEAR_PIN_FILT_CYC
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        supply_rise,
   input  wire logic        brownout,
   input  wire logic        master_clear_pin_i,
   output logic             master_clear_pin_o,
   output logic             master_clear_pin_oe,
   input  wire logic        sleeping,
   input  wire rocs_src_t   src,
   input  wire logic        osc_valid,
   input  wire logic        sys_clk_running,
   input  wire logic        osc_is_crystal,
   output logic             system_reset_n,
   output logic             clock_fail_trap,
   output logic [2:0]       current_osc_group,
   output logic             clock_fail_flag
);
   localparam int PWR_MAX = 64 * MS_CYC;
   localparam int CW      = $clog2(PWR_MAX + 1);
   initial
   begin
      if (POR_CYC < 1 || SETTLE_CYC < 1 || MS_CYC < 1 || FILT_CYC < 2)
         $error("rocs_sequencer: bad timing parameter");
   end

   // oscillator configuration word, written over apb only while system reset is held
   logic [23:0] osc_cfg_word;
   logic [3:0]  frc_trim;
   logic [15:0] reset_control_reg;
   logic        switch_request;
   rocs_state_t state;
   logic [CW-1:0] cnt;

   wire rocs_cfg_t cfg = '{switch_monitor_cfg: osc_cfg_word[15:14],
                           poweron_osc_group:  osc_cfg_word[10:8],
                           primary_osc_select: osc_cfg_word[4:0],
                           powerup_timer:      osc_cfg_word[17:16]};
   wire logic switch_en  = ~cfg.switch_monitor_cfg[1];
   wire logic monitor_en = cfg.switch_monitor_cfg == 2'b00;
   wire logic primary_grp = cfg.poweron_osc_group == `ROCS_GRP_PLL ||
                            cfg.poweron_osc_group == `ROCS_GRP_EXT;
   // mode shown in the osc register when primary or pll is chosen
   wire logic [4:0] primary_mode = primary_grp ? cfg.primary_osc_select : 5'h0_0;

   // two-flop synchronisers for pin and analog inputs
   logic [1:0] sup_s, bor_s, master_clear_pin_s, clk_s;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sup_s  <= 2'b00;
         bor_s  <= 2'b00;
         master_clear_pin_s <= 2'b11;
         clk_s  <= 2'b00;
      end
      else
      begin
         sup_s  <= {sup_s[0], supply_rise};
         bor_s  <= {bor_s[0], brownout};
         master_clear_pin_s <= {master_clear_pin_s[0], master_clear_pin_i};
         clk_s  <= {clk_s[0], sys_clk_running};
      end
   end

   // master-clear noise filter: low must persist FILT_CYC cycles
   logic [$clog2(FILT_CYC+1)-1:0] filt_cnt;
   logic sup_d;
   wire logic master_clear_pin_low  = ~master_clear_pin_s[1];
   wire logic filt_hit  = master_clear_pin_low && filt_cnt == ($bits(filt_cnt))'(FILT_CYC - 1);
   wire logic por_evt   = sup_s[1] & ~sup_d;
   wire logic bor_evt   = bor_s[1];
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         filt_cnt <= '0;
         sup_d    <= 1'b0;
      end
      else
      begin
         sup_d    <= sup_s[1];
         filt_cnt <= !master_clear_pin_low ? '0 : (filt_hit ? filt_cnt : filt_cnt + 1'b1);
      end
   end
   wire logic ext_rst = filt_hit;

   // internal resets never drive the pin
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         master_clear_pin_o  <= 1'b0;
         master_clear_pin_oe <= 1'b0;
      end
      else
      begin
         master_clear_pin_o  <= 1'b1;
         master_clear_pin_oe <= 1'b0;
      end
   end

   // quarter-phase divider; first phase pulse every ROCS_Q_DIV cycles
   logic [1:0] qph;
   wire logic q1_edge = qph == 2'd0;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         qph <= 2'd0;
      else
         qph <= qph + 2'd1;
   end

   // any reset that restarts the sequence
   wire logic hard_rst = por_evt | bor_evt | ext_rst | src.sw_reset |
                         src.wdt_timeout | src.trap_lockup | src.illegal_op;

   // power-up delay selection; crystal with none gets settle delay
   logic [CW-1:0] pwr_len;
   always_comb
   begin
      unique case (cfg.powerup_timer)
         2'd0: pwr_len = osc_is_crystal ? CW'(SETTLE_CYC) : CW'(0);
         2'd1: pwr_len = CW'(`ROCS_PWRT4_MS * MS_CYC);
         2'd2: pwr_len = CW'(`ROCS_PWRT16_MS * MS_CYC);
         2'd3: pwr_len = CW'(`ROCS_PWRT64_MS * MS_CYC);
      endcase
   end
   wire logic fast_exit = pwr_len == '0 && !monitor_en;

   // sequence state: delays count pclk only, never osc_valid
   rocs_state_t next_state;
   logic [CW-1:0] next_cnt;
   always_comb
   begin
      next_state = state;
      next_cnt   = cnt;
      unique case (state)
         ROCS_HOLD:
         begin
            next_state = ROCS_PORWAIT;
            next_cnt   = '0;
         end
         ROCS_PORWAIT:
            if (cnt == CW'(POR_CYC - 1))
            begin
               next_state = fast_exit || pwr_len == '0 ? ROCS_Q1WAIT : ROCS_PWRWAIT;
               next_cnt   = '0;
            end
            else
               next_cnt = cnt + 1'b1;
         ROCS_PWRWAIT:
            if (cnt == pwr_len - 1'b1)
               next_state = ROCS_Q1WAIT;
            else
               next_cnt = cnt + 1'b1;
         ROCS_Q1WAIT:
            if (q1_edge && (monitor_en || clk_s[1]))
               next_state = ROCS_RUN;
         ROCS_RUN:
            next_state = ROCS_RUN;
      endcase
      if (hard_rst)
      begin
         next_state = ROCS_HOLD;
         next_cnt   = '0;
      end
   end
   wire logic release_now = state == ROCS_Q1WAIT && next_state == ROCS_RUN;
   wire logic fail_now    = release_now && monitor_en && !osc_valid;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state          <= ROCS_HOLD;
         cnt            <= '0;
         system_reset_n <= 1'b0;
      end
      else
      begin
         state          <= next_state;
         cnt            <= next_cnt;
         system_reset_n <= next_state == ROCS_RUN;
      end
   end

   // apb decode; zero-wait slave; declared ahead of the osc process that reads wr_osc
   wire logic acc      = psel && penable;
   wire logic hit_trim = paddr == `ROCS_OFF_TRIM;
   wire logic hit_cfg  = paddr == `ROCS_OFF_CFG;
   wire logic hit_stat = paddr == `ROCS_OFF_STAT;
   wire logic hit_osc  = paddr == `ROCS_OFF_OSC;
   wire logic mapped   = hit_trim | hit_cfg | hit_stat | hit_osc;
   wire logic wr_trim  = acc && pwrite && hit_trim;
   wire logic wr_cfg   = acc && pwrite && hit_cfg;
   wire logic wr_stat  = acc && pwrite && hit_stat;
   wire logic wr_osc   = acc && pwrite && hit_osc;

   // oscillator group and clock fail handling
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         current_osc_group <= 3'b000;
         clock_fail_flag   <= 1'b0;
         clock_fail_trap   <= 1'b0;
         switch_request    <= 1'b0;
      end
      else
      begin
         clock_fail_trap <= fail_now;
         if (por_evt || bor_evt)
         begin
            current_osc_group <= cfg.poweron_osc_group;
            clock_fail_flag   <= 1'b0;
            switch_request    <= 1'b0;
         end
         else if (fail_now)
         begin
            current_osc_group <= `ROCS_GRP_FRC;
            clock_fail_flag   <= 1'b1;
            switch_request    <= 1'b0;
         end
         else if (wr_osc && switch_en)
            switch_request <= pwdata[0];
      end
   end

   // read selection
   wire logic [31:0] rd_mux =
      hit_trim ? {28'h000_0000, frc_trim} :
      hit_cfg  ? {8'h00, osc_cfg_word} :
      hit_stat ? {16'h0000, reset_control_reg} :
      hit_osc  ? {17'h0_0000, current_osc_group, 3'b000, primary_mode,
                  clock_fail_flag, 2'b00, switch_request} : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end
   // write takes effect in the access cycle, answered one cycle after setup
   wire logic wr_ok = 1'b1;

   // trim and configuration storage; configuration is programmed, not run-time
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         frc_trim     <= 4'h0;
         osc_cfg_word <= `ROCS_CFG_RESET;
      end
      else
      begin
         if (wr_trim && wr_ok)
            frc_trim <= pwdata[3:0];
         if (wr_cfg && !system_reset_n)
            osc_cfg_word <= {6'h00, pwdata[17:16], pwdata[15:14], 3'b000,
                             pwdata[10:8], 3'b000, pwdata[4:0]};
      end
   end

   // reset cause flags; hardware set beats software clear
   logic [15:0] set_mask;
   logic [15:0] keep_mask;
   always_comb
   begin
      set_mask  = 16'h0000;
      keep_mask = 16'hFFFF;
      if (por_evt)
      begin
         keep_mask = 16'h0000;
         set_mask  = 16'h0003;
      end
      else if (bor_evt)
      begin
         keep_mask[`ROCS_ST_POR] = 1'b0;
         set_mask[`ROCS_ST_BOR]  = 1'b1;
      end
      else
      begin
         if (ext_rst)
         begin
            keep_mask[`ROCS_ST_WDTO]   = 1'b0;
            set_mask[`ROCS_ST_EXTR]    = 1'b1;
            set_mask[`ROCS_ST_SLEEP]   = sleeping;
            keep_mask[`ROCS_ST_SLEEP]  = 1'b0;
            keep_mask[`ROCS_ST_SWR]    = sleeping;
         end
         if (src.sw_reset)
         begin
            keep_mask[`ROCS_ST_EXTR] = 1'b0;
            keep_mask[`ROCS_ST_WDTO] = 1'b0;
            keep_mask[`ROCS_ST_SLEEP] = 1'b0;
            set_mask[`ROCS_ST_SWR]   = 1'b1;
         end
         if (src.wdt_timeout)
         begin
            keep_mask[`ROCS_ST_EXTR]  = 1'b0;
            keep_mask[`ROCS_ST_SWR]   = 1'b0;
            keep_mask[`ROCS_ST_SLEEP] = 1'b0;
            set_mask[`ROCS_ST_WDTO]   = 1'b1;
         end
         if (src.wdt_wake)
         begin
            set_mask[`ROCS_ST_WDTO]  = 1'b1;
            set_mask[`ROCS_ST_SLEEP] = 1'b1;
         end
         set_mask[`ROCS_ST_TRAP] = src.trap_lockup;
         set_mask[`ROCS_ST_IOP]  = src.illegal_op;
      end
   end
   wire logic [15:0] sw_keep = wr_stat ? pwdata[15:0] : 16'hFFFF;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         reset_control_reg <= 16'h0003;
      else
         reset_control_reg <= (reset_control_reg & keep_mask & sw_keep) | set_mask;
   end
endmodule
`default_nettype wire

// ===== verification/rocs_partner.sv
// model of the core, supply detector and master-clear pin
`default_nettype none
module rocs_partner
   import rocs_pkg::*;
(
   input  wire logic pclk,
   output logic      supply_rise,
   output logic      brownout,
   output logic      pin,
   output logic      sleeping,
   output rocs_src_t src,
   output logic      osc_valid,
   output logic      sys_clk_running,
   output logic      osc_is_crystal
);
   timeunit 1ns;
   timeprecision 1ns;
   // quiet supply, pin left on its pull-up, clock running
   initial
   begin
      supply_rise = 1'b0;
      brownout = 1'b0;
      pin = 1'b1;
      src = '0;
      {sleeping, osc_valid, sys_clk_running, osc_is_crystal} = 4'b0110;
   end
   task automatic pulse(input int b);
      @(posedge pclk);
      src[b] <= 1'b1;
      @(posedge pclk);
      src <= '0;
   endtask
   // long enough for the level to cross the synchroniser
   task automatic bor(input logic v);
      @(posedge pclk);
      brownout <= v;
      repeat (6) @(posedge pclk);
   endtask
   task automatic clr(input int n);
      @(posedge pclk);
      pin <= 1'b0;
      repeat (n) @(posedge pclk);
      pin <= 1'b1;
   endtask
   task automatic por();
      @(posedge pclk);
      supply_rise <= 1'b1;
      repeat (4) @(posedge pclk);
      supply_rise <= 1'b0;
   endtask
   task automatic set(input logic s, v, r, x);
      @(posedge pclk);
      {sleeping, osc_valid, sys_clk_running, osc_is_crystal} <= {s, v, r, x};
   endtask
endmodule
`default_nettype wire

// ===== verification/rocs_sequencer_asserts.sv
// port assertions for the reset and oscillator sequencer
`include "rocs_defs.svh"
`default_nettype none
module rocs_sequencer_chk
   import rocs_pkg::*;
#(
   parameter int POR_CYC = 4
)
(
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic       sleeping,
   input wire rocs_src_t  src,
   input wire logic       master_clear_pin_oe,
   input wire logic       system_reset_n,
   input wire logic       clock_fail_trap,
   input wire logic [2:0] current_osc_group,
   input wire logic       clock_fail_flag
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // pin stays an input whatever the reset source
   a_pin_not_driven: assert property (!master_clear_pin_oe)
      else $error("clear pin driven");
   // zero wait slave, one-cycle answer
   a_apb_zero_wait: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   // hold lasts at least the power-on delay
   a_por_hold_min: assert property ($rose(system_reset_n) |-> $past(!system_reset_n, POR_CYC))
      else $error("reset released early");
   a_fail_to_frc: assert property (clock_fail_trap |-> ##[0:1] (clock_fail_flag && current_osc_group == `ROCS_GRP_FRC))
      else $error("trap without frc switch");
   a_wake_keeps_run: assert property (src.wdt_wake && sleeping && system_reset_n |=> system_reset_n [*4])
      else $error("wake caused reset");
   a_sw_resets: assert property (src.sw_reset && system_reset_n |-> ##[1:6] !system_reset_n)
      else $error("software reset missed");
endmodule
bind rocs_sequencer rocs_sequencer_chk #(.POR_CYC(POR_CYC)) u_chk (.pclk, .presetn, .psel,
   .penable, .pready, .pslverr, .sleeping, .src, .master_clear_pin_oe, .system_reset_n,
   .clock_fail_trap, .current_osc_group, .clock_fail_flag);
`default_nettype wire

// ===== verification/tb_top.sv
// self-checking bench for the reset and oscillator sequencer
`include "rocs_defs.svh"
`default_nettype none
module tb_top
   import rocs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int POR = 4, SET = 5, MS = 10;
   localparam logic [11:0] AT = `ROCS_OFF_TRIM, AC = `ROCS_OFF_CFG, AS = `ROCS_OFF_STAT;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, rise, bor;
   logic        pin_i, pin_o, pin_oe, pm_pin, slp, ov, run, xt, rst_n, trap, ff;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, tr;
   logic [2:0]  grp;
   rocs_src_t   src;
   int          n_mismatch = 0, n_compared = 0, seed = 32'hd352, ntrap = 0, i, k, c;
   int          pw[4] = '{0, 4, 16, 64};
   logic [31:0] ex[8] = '{32'h0000_0040, 32'h0000_0010, 32'h0000_8000, 32'h0000_4000,
                          32'h0000_0080, 32'h0000_0088, 32'h0000_0002, 32'h0000_0018};
   // pull-up: only a driving party pulls the pin low
   assign pin_i = pin_oe ? pin_o : pm_pin;
   rocs_sequencer #(.POR_CYC(POR), .SETTLE_CYC(SET), .MS_CYC(MS), .FILT_CYC(4)) DUT (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .supply_rise(rise), .brownout(bor), .master_clear_pin_i(pin_i),
      .master_clear_pin_o(pin_o), .master_clear_pin_oe(pin_oe), .sleeping(slp), .src,
      .osc_valid(ov), .sys_clk_running(run), .osc_is_crystal(xt), .system_reset_n(rst_n),
      .clock_fail_trap(trap), .current_osc_group(grp), .clock_fail_flag(ff));
   rocs_partner pm (.pclk, .supply_rise(rise), .brownout(bor), .pin(pm_pin), .sleeping(slp),
      .src, .osc_valid(ov), .sys_clk_running(run), .osc_is_crystal(xt));
   task automatic finish_test();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one transfer; request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      rd = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
      if (n >= 50)
         finish_test();
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] x, input logic er);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, x);
      chk({31'h0, e}, {31'h0, er});
   endtask
   task automatic wrel(input int lo, input int hi);
      int n;
      n = 0;
      while (rst_n !== 1'b1 && n < hi + 50)
      begin
         @(negedge pclk);
         n++;
      end
      chk(n >= lo && n <= hi, 1);
      if (n >= hi + 50)
         finish_test();
   endtask
   task automatic stay(input int n, output int lo);
      lo = 0;
      repeat (n)
      begin
         @(negedge pclk);
         lo += (rst_n !== 1'b1);
      end
   endtask
   // count trap pulses away from the launching edge
   always @(negedge pclk)
      if (trap === 1'b1)
         ntrap++;
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      wrel(POR, POR + 12);
      rchk(AS, 32'h0000_0003, 1'b0);
      rchk(AC, `ROCS_CFG_RESET, 1'b0);
      rchk(12'h010, 32'h0000_0000, 1'b1);
      rchk(AT, 32'h0000_0000, 1'b0);
      for (k = 0; k < 7; k++)
      begin
         tr = (k == 0) ? 32'h0000_0007 : (k == 2) ? 32'h0000_0008 : $random(seed);
         tr = (k == 1) ? 32'h0000_0000 : tr;
         apb(1'b1, AT, tr);
         rchk(AT, tr & 32'h0000_000F, 1'b0);
      end
      $display("trim done");
      // one cause per pass, the last a watchdog wake that must not reset; flags cleared beforehand
      for (k = 0; k < 8; k++)
      begin
         apb(1'b1, AS, 32'h0000_0000);
         tr = $random(seed);
         apb(1'b1, AT, tr);
         pm.set(k == 5 || k == 7, 1'b1, 1'b1, 1'b0);
         if (k < 4)
            pm.pulse(k < 2 ? 4 - k : 3 - k);
         else if (k < 6)
            pm.clr(8);
         else if (k == 6)
         begin
            pm.bor(1'b1);
            pm.bor(1'b0);
         end
         else
            pm.pulse(2);
         stay(8, c);
         chk(c > 0, k < 7);
         if (k == 7)
            rchk(AT, tr & 32'h0000_000F, 1'b0);
         wrel(0, 3000);
         pm.set(1'b0, 1'b1, 1'b1, 1'b0);
         rchk(AS, ex[k], 1'b0);
      end
      $display("causes done");
      apb(1'b1, AS, 32'h0000_0000);
      pm.clr(2);
      stay(20, c);
      chk(c, 0);
      rchk(AS, 32'h0000_0000, 1'b0);
      for (k = 0; k < 5; k++)
      begin
         pm.set(1'b0, 1'b0, 1'b1, k == 4);
         pm.bor(1'b1);
         apb(1'b1, AC, 32'h0000_C100 | ((k & 3) << 16));
         pm.bor(1'b0);
         i = POR + ((k < 4) ? pw[k] * MS : SET);
         wrel(i - 1, i + 12);
      end
      $display("delays done");
      pm.set(1'b0, 1'b1, 1'b0, 1'b0);
      pm.bor(1'b1);
      pm.bor(1'b0);
      stay(60, c);
      chk(c, 60);
      pm.set(1'b0, 1'b1, 1'b1, 1'b0);
      wrel(0, 20);
      pm.bor(1'b1);
      apb(1'b1, AC, 32'h0000_C700);
      pm.bor(1'b0);
      wrel(0, 40);
      chk({29'h0, grp}, 32'h0000_0007);
      pm.set(1'b0, 1'b0, 1'b1, 1'b0);
      pm.bor(1'b1);
      apb(1'b1, AC, 32'h0000_0300);
      pm.bor(1'b0);
      wrel(POR - 1, POR + 12);
      stay(4, c);
      chk(ntrap, 1);
      chk({28'h0, ff, grp}, 32'h0000_0009);
      apb(1'b0, `ROCS_OFF_OSC, 32'h0000_0000);
      chk(rd & 32'h0000_7009, 32'h0000_1008);
      $display("clock fail done");
      apb(1'b1, AS, 32'h0000_0000);
      pm.por();
      stay(8, c);
      chk(c > 0, 1);
      wrel(0, 3000);
      rchk(AS, 32'h0000_0003, 1'b0);
      $display("power-on done");
      finish_test();
   end
endmodule
`default_nettype wire
